// [inc/pmc_map.vh]
// register map constants for the modulator control register bank
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_ADDR_W 7
`define PMC_DATA_W 16
`define PMC_OFF_MOD_Q 7'h33
`define PMC_OFF_DET_PUMP 7'h40
`define PMC_OFF_DITHER_A 7'h42
`define PMC_OFF_DITHER_SEED 7'h43
`define PMC_OFF_OSC_BAND 7'h45
`define PMC_OFF_OSC_TUNE 7'h49
`define PMC_RST_MOD_Q 16'h0000
`define PMC_RST_DET_PUMP 16'h0010
`define PMC_RST_DITHER_A 16'h000E
`define PMC_RST_DITHER_SEED 16'h0000
`define PMC_RST_OSC_BAND 16'h0000
`define PMC_RST_OSC_TUNE 16'h16BD
`define PMC_MASK_MOD_Q 16'h00FF
`define PMC_MASK_DET_PUMP 16'h007F
`define PMC_MASK_DITHER_A 16'h000F
`define PMC_MASK_DITHER_SEED 16'hFFFF
`define PMC_MASK_OSC_BAND 16'h03FF
`define PMC_MASK_OSC_TUNE 16'h3FFF
`define PMC_PUMP_NORMAL 3'h4
`define PMC_PUMP_TRISTATE 3'h3
`endif

// [design/pmc_field_reg.v]
// one masked read/write control register with reset value
`timescale 1ns/10ps
module pmc_field_reg #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] WRITE_MASK = {WIDTH{1'b1}}
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire wr_en_in,
  input wire [WIDTH-1:0] wr_data_in,
  output reg [WIDTH-1:0] value_out
);
  // unlisted bits stay zero and ignore writes
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      value_out <= RESET_VALUE & WRITE_MASK;
    end else if (wr_en_in) begin
      value_out <= wr_data_in & WRITE_MASK;
    end
  end
endmodule // pmc_field_reg

// [design/pmc_ctrl_regs.v]
// control register bank for detector, pump, dither and oscillator band
// What this block does
// - q carrier null: sign-magnitude 8 bits, 5 uA steps
// - detector pump register at 0x40, reset 0x0010
// - pump override 3 bits, reset normal 100
// - two edge select bits choose detector edges
// - antibacklash delay 2 bits, default zero delay
// - dither register 0x42, reset 0x000E, three fields
// - dither seed word 0x43, 16 bits, reset zero
// - tune source 2 bits, 00 is calibration
// - band source selects calibration or manual band
// - oscillator band register 0x45 resets to zero
`timescale 1ns/10ps
`include "pmc_map.vh"
module pmc_ctrl_regs (
  input wire CLK_SYS_IN,
  input wire RST_N_IN,
  input wire WR_EN_IN,
  input wire [`PMC_ADDR_W-1:0] ADDR_IN,
  input wire [`PMC_DATA_W-1:0] WR_DATA_IN,
  output reg [`PMC_DATA_W-1:0] RD_DATA_OUT,
  output reg RD_HIT_OUT,
  input wire [6:0] CAL_BAND_IN,
  output reg [7:0] Q_CARRIER_NULL_OFFSET_OUT,
  output reg Q_NULL_NEGATIVE_OUT,
  output reg [6:0] Q_NULL_MAGNITUDE_OUT,
  output reg [1:0] ANTIBACKLASH_DELAY_OUT,
  output reg [2:0] PUMP_OVERRIDE_OUT,
  output reg PUMP_UP_OUT,
  output reg PUMP_DOWN_OUT,
  output reg PUMP_TRISTATE_OUT,
  output reg DIVIDER_RISING_OUT,
  output reg REFERENCE_RISING_OUT,
  output reg DITHER_ON_OUT,
  output reg [1:0] DITHER_MAGNITUDE_OUT,
  output reg DITHER_SEED_BIT_OUT,
  output reg [15:0] DITHER_SEED_OUT,
  output reg [1:0] TUNE_SOURCE_OUT,
  output reg TUNE_FROM_CAL_OUT,
  output reg BAND_SOURCE_OUT,
  output reg [6:0] OSC_BAND_OUT,
  output reg [4:0] TUNING_SET_HIGH_OUT,
  output reg [8:0] TUNING_SET_LOW_OUT
);
  // ==========================================================
  // register storage
  wire [`PMC_DATA_W-1:0] mod_q;
  wire [`PMC_DATA_W-1:0] det_pump;
  wire [`PMC_DATA_W-1:0] dither_a;
  wire [`PMC_DATA_W-1:0] dither_seed_word;
  wire [`PMC_DATA_W-1:0] osc_band;
  wire [`PMC_DATA_W-1:0] osc_tune;
  reg [6:0] cal_band_meta;
  reg [6:0] cal_band_sync;

  pmc_field_reg #(.WIDTH(`PMC_DATA_W), .RESET_VALUE(`PMC_RST_MOD_Q),
    .WRITE_MASK(`PMC_MASK_MOD_Q)) u_mod_q (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
    .wr_en_in(WR_EN_IN && ADDR_IN == `PMC_OFF_MOD_Q),
    .wr_data_in(WR_DATA_IN), .value_out(mod_q));
  pmc_field_reg #(.WIDTH(`PMC_DATA_W), .RESET_VALUE(`PMC_RST_DET_PUMP),
    .WRITE_MASK(`PMC_MASK_DET_PUMP)) u_det_pump (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
    .wr_en_in(WR_EN_IN && ADDR_IN == `PMC_OFF_DET_PUMP),
    .wr_data_in(WR_DATA_IN), .value_out(det_pump));
  pmc_field_reg #(.WIDTH(`PMC_DATA_W), .RESET_VALUE(`PMC_RST_DITHER_A),
    .WRITE_MASK(`PMC_MASK_DITHER_A)) u_dither_a (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
    .wr_en_in(WR_EN_IN && ADDR_IN == `PMC_OFF_DITHER_A),
    .wr_data_in(WR_DATA_IN), .value_out(dither_a));
  pmc_field_reg #(.WIDTH(`PMC_DATA_W), .RESET_VALUE(`PMC_RST_DITHER_SEED),
    .WRITE_MASK(`PMC_MASK_DITHER_SEED)) u_dither_seed (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
    .wr_en_in(WR_EN_IN && ADDR_IN == `PMC_OFF_DITHER_SEED),
    .wr_data_in(WR_DATA_IN), .value_out(dither_seed_word));
  pmc_field_reg #(.WIDTH(`PMC_DATA_W), .RESET_VALUE(`PMC_RST_OSC_BAND),
    .WRITE_MASK(`PMC_MASK_OSC_BAND)) u_osc_band (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
    .wr_en_in(WR_EN_IN && ADDR_IN == `PMC_OFF_OSC_BAND),
    .wr_data_in(WR_DATA_IN), .value_out(osc_band));
  pmc_field_reg #(.WIDTH(`PMC_DATA_W), .RESET_VALUE(`PMC_RST_OSC_TUNE),
    .WRITE_MASK(`PMC_MASK_OSC_TUNE)) u_osc_tune (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
    .wr_en_in(WR_EN_IN && ADDR_IN == `PMC_OFF_OSC_TUNE),
    .wr_data_in(WR_DATA_IN), .value_out(osc_tune));

  // ==========================================================
  // calibration band from analog side, two-stage synchroniser
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      cal_band_meta <= 7'h00;
      cal_band_sync <= 7'h00;
    end else begin
      cal_band_meta <= CAL_BAND_IN;
      cal_band_sync <= cal_band_meta;
    end
  end

  // ==========================================================
  // readback, registered, unmapped reads zero
  reg [`PMC_DATA_W-1:0] next_rd_data;
  reg next_rd_hit;
  always @* begin
    next_rd_hit = 1'b1;
    case (ADDR_IN)
      `PMC_OFF_MOD_Q: next_rd_data = mod_q;
      `PMC_OFF_DET_PUMP: next_rd_data = det_pump;
      `PMC_OFF_DITHER_A: next_rd_data = dither_a;
      `PMC_OFF_DITHER_SEED: next_rd_data = dither_seed_word;
      `PMC_OFF_OSC_BAND: next_rd_data = osc_band;
      `PMC_OFF_OSC_TUNE: next_rd_data = osc_tune;
      default: begin
        next_rd_data = 16'h0000;
        next_rd_hit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // decoded field outputs, registered
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      RD_DATA_OUT <= 16'h0000;
      RD_HIT_OUT <= 1'b0;
      Q_CARRIER_NULL_OFFSET_OUT <= 8'h00;
      Q_NULL_NEGATIVE_OUT <= 1'b0;
      Q_NULL_MAGNITUDE_OUT <= 7'h00;
      ANTIBACKLASH_DELAY_OUT <= 2'h0;
      PUMP_OVERRIDE_OUT <= `PMC_PUMP_NORMAL;
      PUMP_UP_OUT <= 1'b0;
      PUMP_DOWN_OUT <= 1'b0;
      PUMP_TRISTATE_OUT <= 1'b0;
      DIVIDER_RISING_OUT <= 1'b0;
      REFERENCE_RISING_OUT <= 1'b0;
      DITHER_ON_OUT <= 1'b1;
      DITHER_MAGNITUDE_OUT <= 2'h3;
      DITHER_SEED_BIT_OUT <= 1'b0;
      DITHER_SEED_OUT <= 16'h0000;
      TUNE_SOURCE_OUT <= 2'h0;
      TUNE_FROM_CAL_OUT <= 1'b1;
      BAND_SOURCE_OUT <= 1'b0;
      OSC_BAND_OUT <= 7'h00;
      TUNING_SET_HIGH_OUT <= 5'h0B;
      TUNING_SET_LOW_OUT <= 9'h0BD;
    end else begin
      RD_DATA_OUT <= next_rd_data;
      RD_HIT_OUT <= next_rd_hit;
      Q_CARRIER_NULL_OFFSET_OUT <= mod_q[7:0];
      // top-bit-only code is zero offset, not negative zero
      Q_NULL_NEGATIVE_OUT <= mod_q[7] && (mod_q[6:0] != 7'h00);
      Q_NULL_MAGNITUDE_OUT <= mod_q[6:0];
      ANTIBACKLASH_DELAY_OUT <= det_pump[6:5];
      PUMP_OVERRIDE_OUT <= det_pump[4:2];
      case (det_pump[4:2])
        3'h0: begin
          PUMP_UP_OUT <= 1'b1;
          PUMP_DOWN_OUT <= 1'b1;
          PUMP_TRISTATE_OUT <= 1'b0;
        end
        3'h1: begin
          PUMP_UP_OUT <= 1'b0;
          PUMP_DOWN_OUT <= 1'b1;
          PUMP_TRISTATE_OUT <= 1'b0;
        end
        3'h2: begin
          PUMP_UP_OUT <= 1'b1;
          PUMP_DOWN_OUT <= 1'b0;
          PUMP_TRISTATE_OUT <= 1'b0;
        end
        `PMC_PUMP_TRISTATE: begin
          PUMP_UP_OUT <= 1'b0;
          PUMP_DOWN_OUT <= 1'b0;
          PUMP_TRISTATE_OUT <= 1'b1;
        end
        default: begin
          // detector-driven: no forcing
          PUMP_UP_OUT <= 1'b0;
          PUMP_DOWN_OUT <= 1'b0;
          PUMP_TRISTATE_OUT <= 1'b0;
        end
      endcase
      DIVIDER_RISING_OUT <= det_pump[1];
      REFERENCE_RISING_OUT <= det_pump[0];
      DITHER_ON_OUT <= dither_a[3];
      DITHER_MAGNITUDE_OUT <= dither_a[2:1];
      DITHER_SEED_BIT_OUT <= dither_a[0];
      DITHER_SEED_OUT <= dither_seed_word;
      TUNE_SOURCE_OUT <= osc_band[9:8];
      TUNE_FROM_CAL_OUT <= (osc_band[9:8] == 2'h0);
      BAND_SOURCE_OUT <= osc_band[7];
      OSC_BAND_OUT <= osc_band[7] ? osc_band[6:0] : cal_band_sync;
      TUNING_SET_HIGH_OUT <= osc_tune[13:9];
      TUNING_SET_LOW_OUT <= osc_tune[8:0];
    end
  end
endmodule // pmc_ctrl_regs

// [tb/pmc_ctrl_sva.sv]
// assertions on the ports of the control register bank
`timescale 1ns/10ps
module pmc_ctrl_sva (
  input wire CLK_SYS_IN, RST_N_IN, WR_EN_IN, RD_HIT_OUT, PUMP_TRISTATE_OUT, Q_NULL_NEGATIVE_OUT,
  input wire DITHER_ON_OUT, TUNE_FROM_CAL_OUT, BAND_SOURCE_OUT,
  input wire [6:0] ADDR_IN, OSC_BAND_OUT, Q_NULL_MAGNITUDE_OUT,
  input wire [7:0] Q_CARRIER_NULL_OFFSET_OUT,
  input wire [15:0] WR_DATA_IN, RD_DATA_OUT, DITHER_SEED_OUT,
  input wire [2:0] PUMP_OVERRIDE_OUT,
  input wire [1:0] ANTIBACKLASH_DELAY_OUT, DITHER_MAGNITUDE_OUT, TUNE_SOURCE_OUT,
  input wire [4:0] TUNING_SET_HIGH_OUT,
  input wire [8:0] TUNING_SET_LOW_OUT
);
  // ========
  // properties
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence wr_at(a); WR_EN_IN && ADDR_IN == a; endsequence
  reset_defaults_a: assert property ($rose(RST_N_IN) |-> PUMP_OVERRIDE_OUT == 3'h4
    && ANTIBACKLASH_DELAY_OUT == 2'h0 && DITHER_ON_OUT && DITHER_MAGNITUDE_OUT == 2'h3
    && TUNING_SET_HIGH_OUT == 5'h0b && TUNING_SET_LOW_OUT == 9'h0bd) else $error("bad defaults");
  pump_field_a: assert property (wr_at(7'h40) |=> ##1 {ANTIBACKLASH_DELAY_OUT,
    PUMP_OVERRIDE_OUT} == $past(WR_DATA_IN[6:2], 2)) else $error("pump fields wrong");
  pump_decode_a: assert property (PUMP_TRISTATE_OUT == (PUMP_OVERRIDE_OUT == 3'h3))
    else $error("tristate decode wrong");
  q_null_a: assert property (Q_NULL_MAGNITUDE_OUT == Q_CARRIER_NULL_OFFSET_OUT[6:0]
    && Q_NULL_NEGATIVE_OUT == (Q_CARRIER_NULL_OFFSET_OUT[7] && Q_NULL_MAGNITUDE_OUT != 7'h00))
    else $error("q null decode wrong");
  dither_write_a: assert property (wr_at(7'h42) |=> ##1 {DITHER_ON_OUT,
    DITHER_MAGNITUDE_OUT} == $past(WR_DATA_IN[3:1], 2)) else $error("dither fields wrong");
  seed_write_a: assert property (wr_at(7'h43) |=> ##1 DITHER_SEED_OUT == $past(WR_DATA_IN, 2))
    else $error("seed word wrong");
  tune_cal_a: assert property (TUNE_FROM_CAL_OUT == (TUNE_SOURCE_OUT == 2'h0))
    else $error("tune source decode wrong");
  band_manual_a: assert property (wr_at(7'h45) ##0 WR_DATA_IN[7] |=> ##1 BAND_SOURCE_OUT
    && OSC_BAND_OUT == $past(WR_DATA_IN[6:0], 2)) else $error("manual band wrong");
  unmapped_read_a: assert property ($past(RST_N_IN) && $past(ADDR_IN) == 7'h41
    |-> !RD_HIT_OUT && RD_DATA_OUT == 16'h0000) else $error("unmapped read not zero");
endmodule // pmc_ctrl_sva
bind pmc_ctrl_regs pmc_ctrl_sva chk (.*);

// [tb/pmc_host.sv]
// host model writing and reading the register bank
`timescale 1ns/10ps
module pmc_host (
  input wire clk_in,
  input wire [15:0] rd_data_in,
  input wire rd_hit_in,
  output reg wr_en_out = 1'b0,
  output reg [6:0] addr_out = 7'h00,
  output reg [15:0] wr_data_out = 16'h0000
);
  // ========
  // access tasks, strobe stays high so writes run back to back
  task wr(input [6:0] a, input [15:0] d);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wr_data_out <= d;
    @(posedge clk_in);
  endtask
  task idle(input int n);
    wr_en_out <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask
  task rd(input [6:0] a, output [15:0] d, output h);
    wr_en_out <= 1'b0;
    addr_out <= a;
    repeat (2) @(posedge clk_in);
    #1;
    d = rd_data_in;
    h = rd_hit_in;
    @(posedge clk_in);
  endtask
endmodule // pmc_host

// [tb/pmc_tb.sv]
// self-checking bench for the control register bank
`timescale 1ns/10ps
module tb;
  reg clk = 1'b0, rst_n = 1'b0;
  reg [6:0] cal_band = 7'h2a;
  reg [15:0] d;
  reg h;
  int i, n_mismatch = 0, checks_done = 0;
  wire wr_en, rd_hit, q_neg, up, dn, pz, div_r, ref_r, d_on, d_bit, t_cal, b_src;
  wire [6:0] addr, q_mag, band;
  wire [15:0] wr_data, rd_data, seed;
  wire [2:0] ovr;
  wire [1:0] abl, d_mag, t_src;
  wire [4:0] set_hi;
  wire [8:0] set_lo;
  localparam logic [6:0] offs [6] = '{7'h33, 7'h40, 7'h42, 7'h43, 7'h45, 7'h49};
  localparam logic [15:0] rstv [6] = '{16'h0000, 16'h0010, 16'h000e, 16'h0000, 16'h0000, 16'h16bd};
  localparam logic [15:0] mask [6] = '{16'h00ff, 16'h007f, 16'h000f, 16'hffff, 16'h03ff, 16'h3fff};
  localparam logic [7:0] qv [5] = '{8'h00, 8'h7f, 8'h80, 8'hff, 8'h81};
  always #4 clk = ~clk;
  pmc_host host (.clk_in(clk), .rd_data_in(rd_data), .rd_hit_in(rd_hit), .wr_en_out(wr_en),
    .addr_out(addr), .wr_data_out(wr_data));
  pmc_ctrl_regs dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .WR_EN_IN(wr_en), .ADDR_IN(addr),
    .WR_DATA_IN(wr_data), .RD_DATA_OUT(rd_data), .RD_HIT_OUT(rd_hit), .CAL_BAND_IN(cal_band),
    .Q_CARRIER_NULL_OFFSET_OUT(), .Q_NULL_NEGATIVE_OUT(q_neg), .Q_NULL_MAGNITUDE_OUT(q_mag),
    .ANTIBACKLASH_DELAY_OUT(abl), .PUMP_OVERRIDE_OUT(ovr), .PUMP_UP_OUT(up), .PUMP_DOWN_OUT(dn),
    .PUMP_TRISTATE_OUT(pz), .DIVIDER_RISING_OUT(div_r), .REFERENCE_RISING_OUT(ref_r),
    .DITHER_ON_OUT(d_on), .DITHER_MAGNITUDE_OUT(d_mag), .DITHER_SEED_BIT_OUT(d_bit),
    .DITHER_SEED_OUT(seed), .TUNE_SOURCE_OUT(t_src), .TUNE_FROM_CAL_OUT(t_cal),
    .BAND_SOURCE_OUT(b_src), .OSC_BAND_OUT(band), .TUNING_SET_HIGH_OUT(set_hi),
    .TUNING_SET_LOW_OUT(set_lo));
  // ========
  // helpers
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task put(input [6:0] a, input [15:0] dv);
    host.wr(a, dv);
    host.idle(2);
  endtask
  task finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      host.rd(offs[i], d, h);
      check(d, rstv[i]);
      check(h, 1'b1);
    end
    put(7'h49, 16'h1234);
    check({set_hi, set_lo}, 14'h1234);
    for (i = 0; i < 6; i++) host.wr(offs[i], 16'hffff);
    for (i = 0; i < 6; i++) begin
      host.rd(offs[i], d, h);
      check(d, mask[i]);
    end
    host.wr(7'h41, 16'hffff);
    host.rd(7'h41, d, h);
    check({h, d}, 17'h0_0000);
    for (i = 0; i < 5; i++) begin
      put(7'h40, {9'h000, i[1:0], i[2:0], i[1:0]});
      check(ovr, i[2:0]);
      check({up, dn, pz}, {i == 0 || i == 2, i < 2, i == 3});
      check({div_r, ref_r}, i[1:0]);
      check(abl, i[1:0]);
    end
    for (i = 0; i < 5; i++) begin
      put(7'h33, {8'h00, qv[i]});
      check({q_neg, q_mag}, {qv[i][7] && qv[i][6:0] != 7'h00, qv[i][6:0]});
    end
    put(7'h42, 16'h0005);
    check({d_on, d_mag, d_bit}, 4'h5);
    put(7'h43, 16'ha5c3);
    check(seed, 16'ha5c3);
    put(7'h45, 16'h0000);
    check({t_cal, band}, 8'haa);
    put(7'h45, 16'h01d5);
    check({t_src, t_cal, b_src, band}, 11'h0ad5);
    finish_test;
  end
endmodule // tb
